// *** hdl/flash_self_program_sequencer.sv ***
// run-time self-programming sequencer for on-chip program flash
// assumes register write strobes and the flash array share clk_i
//
// What this block does
// - supports one-page erase and two-word program operations
// - stalls the processor while an operation is in progress
// - writing one to control bit 15 launches the chosen operation
// - hardware clears the start bit when the operation completes
// - program writes two adjacent 24-bit words on a pair boundary
// - keys 0x55 then 0xaa back to back unlock one launch
// - the key register is write-only and reads return zero
// - high byte plus low halfword form the 24-bit target address
`timescale 1ns/1ps
module flash_self_program_sequencer
    import flash_seq_pkg::*;
#(
    parameter int PAGE_ADDR_BITS = PAGE_ADDR_BITS_D
)(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // register writes from the processor
    input  wire logic              ctrl_wr_i,
    input  wire logic [CTRL_W-1:0] ctrl_wdata_i,
    input  wire logic              key_wr_i,
    input  wire logic [7:0]        key_wdata_i,
    input  wire logic              addr_high_wr_i,
    input  wire logic [7:0]        addr_high_wdata_i,
    input  wire logic              addr_low_wr_i,
    input  wire logic [15:0]       addr_low_wdata_i,
    input  wire logic              other_wr_i,
    input  wire logic [WORD_W-1:0] prog_word0_i,
    input  wire logic [WORD_W-1:0] prog_word1_i,
    // register readback and processor control
    output logic [CTRL_W-1:0]      ctrl_rdata_o,
    output logic [7:0]             key_rdata_o,
    output logic [7:0]             addr_high_rdata_o,
    output logic [15:0]            addr_low_rdata_o,
    output logic                   cpu_stall_o,
    // flash array side
    output logic                   flash_req_o,
    output logic                   flash_erase_o,
    output logic [ADDR_W-1:0]      flash_addr_o,
    output logic [ADDR_W-1:0]      flash_addr2_o,
    output logic [WORD_W-1:0]      flash_data0_o,
    output logic [WORD_W-1:0]      flash_data1_o,
    input  wire logic              flash_done_i
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (PAGE_ADDR_BITS < PAIR_ALIGN_BITS + 1 || PAGE_ADDR_BITS >= ADDR_W)
    begin : g_bad_page
        $error("page address bits out of range");
    end

    // the two address halves must tile the flash address exactly
    if (ADDR_HIGH_W + ADDR_LOW_W != ADDR_W) begin : g_bad_addr
        $error("address halves do not form the flash address");
    end

    if (CTRL_START_POS >= CTRL_W || CTRL_ERASE_POS >= CTRL_W)
    begin : g_bad_ctrl
        $error("control bit position outside the register");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IDLE   = 3'b001,
        LAUNCH = 3'b010,
        BUSY   = 3'b100
    } seq_state_t;

    typedef struct packed {
        seq_state_t              st;
        logic                    erase;
        logic [ADDR_HIGH_W-1:0]  addr_high;
        logic [ADDR_LOW_W-1:0]   addr_low;
        logic                    req;
        logic                    op_erase;
        logic [ADDR_W-1:0]       addr;
        logic [ADDR_W-1:0]       addr2;
        logic [WORD_W-1:0]       data0;
        logic [WORD_W-1:0]       data1;
    } seq_regs_t;

    seq_regs_t state_reg;
    seq_regs_t state_next;

    logic armed;
    logic start_try;
    logic [ADDR_W-1:0] ea;
    logic stray_wr;
    logic launch_ok;
    logic busy;

    function automatic logic [ADDR_W-1:0] align_down(
        input logic [ADDR_W-1:0] a,
        input int                bits
    );
        logic [ADDR_W-1:0] mask;
        mask = '1;
        mask = mask << bits;
        return a & mask;
    endfunction : align_down

    // ------------------------------------------------------------
    // unlock
    // ------------------------------------------------------------
    assign start_try = ctrl_wr_i && ctrl_wdata_i[CTRL_START_POS];
    // a control write without the start bit counts as stray
    assign stray_wr  = other_wr_i || addr_high_wr_i || addr_low_wr_i ||
                       (ctrl_wr_i && !ctrl_wdata_i[CTRL_START_POS]);

    unlock_detector u_unlock (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .key_wr_i   (key_wr_i),
        .key_data_i (key_wdata_i),
        .other_wr_i (stray_wr),
        .consume_i  (start_try),
        .armed_o    (armed)
    );

    // unlock only counts while idle; a start while busy still spends it
    assign launch_ok = start_try && armed && (state_reg.st == IDLE);

    // ------------------------------------------------------------
    // target address
    // ------------------------------------------------------------
    assign ea = {state_reg.addr_high, state_reg.addr_low};

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next     = state_reg;
        state_next.req = 1'b0;
        // settings are frozen while an operation runs
        if (state_reg.st == IDLE) begin
            if (ctrl_wr_i) begin
                state_next.erase = ctrl_wdata_i[CTRL_ERASE_POS];
            end
            if (addr_high_wr_i) begin
                state_next.addr_high = addr_high_wdata_i;
            end
            if (addr_low_wr_i) begin
                state_next.addr_low = addr_low_wdata_i;
            end
        end
        unique case (state_reg.st)
            IDLE: begin
                if (launch_ok) begin
                    state_next.st       = LAUNCH;
                    state_next.req      = 1'b1;
                    state_next.op_erase = ctrl_wdata_i[CTRL_ERASE_POS];
                    if (ctrl_wdata_i[CTRL_ERASE_POS]) begin
                        state_next.addr  = align_down(ea, PAGE_ADDR_BITS);
                        state_next.addr2 = align_down(ea, PAGE_ADDR_BITS);
                    end else begin
                        state_next.addr  = align_down(ea, PAIR_ALIGN_BITS);
                        state_next.addr2 = align_down(ea, PAIR_ALIGN_BITS)
                                           + WORD_STEP;
                    end
                    state_next.data0 = prog_word0_i;
                    state_next.data1 = prog_word1_i;
                end
            end
            LAUNCH: begin
                // an answer before the array saw the request is ignored
                state_next.st = BUSY;
            end
            BUSY: begin
                if (flash_done_i) begin
                    state_next.st = IDLE;
                end
            end
            default: state_next.st = IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg.st        <= IDLE;
            state_reg.erase     <= CTRL_RESET[CTRL_ERASE_POS];
            state_reg.addr_high <= ADDR_HIGH_RESET;
            state_reg.addr_low  <= ADDR_LOW_RESET;
            state_reg.req       <= 1'b0;
            state_reg.op_erase  <= 1'b0;
            state_reg.addr      <= ADDR_RESET;
            state_reg.addr2     <= ADDR_RESET;
            state_reg.data0     <= '0;
            state_reg.data1     <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // launch counts as busy so the stall starts with the request
    assign busy = (state_reg.st != IDLE);

    always_comb begin
        ctrl_rdata_o = CTRL_RESET;
        ctrl_rdata_o[CTRL_START_POS] = busy;
        ctrl_rdata_o[CTRL_ERASE_POS] = state_reg.erase;
    end

    // write-only key, nothing stored to read back
    assign key_rdata_o       = '0;
    assign addr_high_rdata_o = state_reg.addr_high;
    assign addr_low_rdata_o  = state_reg.addr_low;
    assign cpu_stall_o       = busy;
    assign flash_req_o       = state_reg.req;
    assign flash_erase_o     = state_reg.op_erase;
    assign flash_addr_o      = state_reg.addr;
    assign flash_addr2_o     = state_reg.addr2;
    assign flash_data0_o     = state_reg.data0;
    assign flash_data1_o     = state_reg.data1;
endmodule : flash_self_program_sequencer

// *** hdl/flash_seq_pkg.sv ***
// constants shared by the flash self-programming sequencer files
// assumes one system clock and an active-high asynchronous reset
package flash_seq_pkg;
    // ------------------------------------------------------------
    // unlock key values
    // ------------------------------------------------------------
    localparam logic [7:0]  KEY_FIRST        = 8'h55;
    localparam logic [7:0]  KEY_SECOND       = 8'haa;
    // ------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------
    localparam int          CTRL_W           = 16;
    localparam int          CTRL_START_POS   = 15;
    localparam int          CTRL_ERASE_POS   = 0;
    localparam logic [15:0] CTRL_RESET       = 16'h0000;
    // ------------------------------------------------------------
    // address and word layout
    // ------------------------------------------------------------
    localparam int          ADDR_W           = 24;
    localparam int          ADDR_HIGH_W      = 8;
    localparam int          ADDR_LOW_W       = 16;
    localparam int          WORD_W           = 24;
    localparam int          PAIR_ALIGN_BITS  = 2;
    localparam logic [23:0] WORD_STEP        = 24'h000002;
    localparam logic [23:0] ADDR_RESET       = 24'h000000;
    localparam logic [7:0]  ADDR_HIGH_RESET  = 8'h00;
    localparam logic [15:0] ADDR_LOW_RESET   = 16'h0000;
    localparam int          PAGE_ADDR_BITS_D = 11;
endpackage : flash_seq_pkg

// *** hdl/unlock_detector.sv ***
// key sequence detector that arms one erase or program launch
// assumes all write strobes are single-cycle pulses on clk_i
`timescale 1ns/1ps
module unlock_detector
    import flash_seq_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       key_wr_i,
    input  wire logic [7:0] key_data_i,
    input  wire logic       other_wr_i,
    input  wire logic       consume_i,
    output logic            armed_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LOCKED   = 3'b001,
        HALF_KEY = 3'b010,
        ARMED    = 3'b100
    } key_state_t;

    typedef struct packed {
        key_state_t st;
    } unlock_state_t;

    unlock_state_t state_reg;
    unlock_state_t state_next;

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg.st)
            LOCKED: begin
                if (key_wr_i && key_data_i == KEY_FIRST) begin
                    state_next.st = HALF_KEY;
                end
            end
            HALF_KEY: begin
                // second key must be the very next register write
                if (key_wr_i && key_data_i == KEY_SECOND) begin
                    state_next.st = ARMED;
                end else if (key_wr_i && key_data_i == KEY_FIRST) begin
                    state_next.st = HALF_KEY;
                end else if (key_wr_i || other_wr_i || consume_i) begin
                    state_next.st = LOCKED;
                end
            end
            ARMED: begin
                // any start attempt spends the unlock, taken or not
                // a stray write after arming cancels it as well
                if (consume_i || other_wr_i) begin
                    state_next.st = LOCKED;
                end else if (key_wr_i) begin
                    state_next.st = (key_data_i == KEY_FIRST) ?
                                    HALF_KEY : LOCKED;
                end
            end
            default: state_next.st = LOCKED;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg.st <= LOCKED;
        end else begin
            state_reg <= state_next;
        end
    end

    assign armed_o = (state_reg.st == ARMED);
endmodule : unlock_detector

// *** verification/flash_array_model.sv ***
// behavioural flash array answering each launch after a delay
// assumes the sequencer's one-cycle request pulse on clk_i
`timescale 1ns/1ps
module flash_array_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       req_i,
    input  wire logic [7:0] delay_i,
    output logic            done_o
);
    // ------------------------------------------------------------
    // operation timer, delay of 1 or more keeps done off the launch
    // ------------------------------------------------------------
    logic [7:0] cnt_reg;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            cnt_reg <= 8'h00;
        else if (req_i)
            cnt_reg <= delay_i;
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
    end
    assign done_o = (cnt_reg == 8'h01);
endmodule : flash_array_model

// *** verification/flash_seq_chk_sva.sv ***
// port checker for the flash self-programming sequencer
// assumes it is bound onto the sequencer top
`timescale 1ns/1ps
module flash_seq_chk
    import flash_seq_pkg::*;
#(
    parameter int PAGE_ADDR_BITS = PAGE_ADDR_BITS_D
)(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              ctrl_wr_i,
    input wire logic [CTRL_W-1:0] ctrl_wdata_i,
    input wire logic              key_wr_i,
    input wire logic [7:0]        key_wdata_i,
    input wire logic              addr_high_wr_i,
    input wire logic              addr_low_wr_i,
    input wire logic              other_wr_i,
    input wire logic [CTRL_W-1:0] ctrl_rdata_o,
    input wire logic [7:0]        key_rdata_o,
    input wire logic [7:0]        addr_high_rdata_o,
    input wire logic [15:0]       addr_low_rdata_o,
    input wire logic              cpu_stall_o,
    input wire logic              flash_req_o,
    input wire logic              flash_erase_o,
    input wire logic [ADDR_W-1:0] flash_addr_o,
    input wire logic [ADDR_W-1:0] flash_addr2_o,
    input wire logic              flash_done_i
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // reference unlock: 2 means the last write completed the keys
    // ------------------------------------------------------------
    logic [1:0] keys_reg;
    logic       any_wr;
    assign any_wr = ctrl_wr_i || addr_high_wr_i || addr_low_wr_i ||
                    other_wr_i;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            keys_reg <= 2'h0;
        end else if (key_wr_i) begin
            if (key_wdata_i == KEY_FIRST) begin
                keys_reg <= 2'h1;
            end else if (key_wdata_i == KEY_SECOND && keys_reg == 2'h1) begin
                keys_reg <= 2'h2;
            end else begin
                keys_reg <= 2'h0;
            end
        end else if (any_wr) begin
            keys_reg <= 2'h0;
        end
    end
    logic [ADDR_W-1:0] ea;
    assign ea = {addr_high_rdata_o, addr_low_rdata_o};
    sequence s_start;
        ctrl_wr_i && ctrl_wdata_i[15];
    endsequence
    sequence s_end;
        cpu_stall_o && !flash_req_o && flash_done_i;
    endsequence
    property p_launch;
        s_start ##1 flash_req_o |-> cpu_stall_o && ctrl_rdata_o[15];
    endproperty
    property p_cause;
        $rose(flash_req_o)
            |-> $past(ctrl_wr_i && ctrl_wdata_i[15] && keys_reg == 2'h2);
    endproperty
    property p_go;
        ctrl_wr_i && ctrl_wdata_i[15] && keys_reg == 2'h2 && !cpu_stall_o
            |=> flash_req_o;
    endproperty
    property p_done;
        s_end |=> !cpu_stall_o && !ctrl_rdata_o[15];
    endproperty
    property p_hold;
        cpu_stall_o && !flash_done_i |=> cpu_stall_o;
    endproperty
    property p_pulse;
        flash_req_o |=> !flash_req_o;
    endproperty
    property p_key;
        key_rdata_o == 8'h00;
    endproperty
    property p_pair;
        flash_req_o && !flash_erase_o |-> flash_addr_o == (ea & ~24'h3)
            && flash_addr2_o == flash_addr_o + WORD_STEP;
    endproperty
    property p_page;
        flash_req_o && flash_erase_o
            |-> flash_addr_o == (ea >> PAGE_ADDR_BITS) << PAGE_ADDR_BITS;
    endproperty
    property p_type;
        flash_req_o |-> flash_erase_o == $past(ctrl_wdata_i[0]);
    endproperty
    a_launch: assert property (p_launch) else $error("no stall on launch");
    a_cause: assert property (p_cause) else $error("launch without start");
    a_go: assert property (p_go) else $error("armed start refused");
    a_done: assert property (p_done) else $error("start bit not cleared");
    a_hold: assert property (p_hold) else $error("stall dropped early");
    a_pulse: assert property (p_pulse) else $error("request too long");
    a_key: assert property (p_key) else $error("key readable");
    a_pair: assert property (p_pair) else $error("pair address wrong");
    a_page: assert property (p_page) else $error("page address wrong");
    a_type: assert property (p_type) else $error("operation type wrong");
endmodule : flash_seq_chk

bind flash_self_program_sequencer flash_seq_chk #(
    .PAGE_ADDR_BITS(PAGE_ADDR_BITS)
) chk (.clk_i, .rst_i, .ctrl_wr_i, .ctrl_wdata_i, .ctrl_rdata_o,
    .key_wr_i, .key_wdata_i, .addr_high_wr_i, .addr_low_wr_i, .other_wr_i,
    .key_rdata_o, .addr_high_rdata_o, .addr_low_rdata_o, .cpu_stall_o,
    .flash_req_o, .flash_erase_o, .flash_addr_o, .flash_addr2_o,
    .flash_done_i);

// *** verification/flash_self_program_sequencer_bench.sv ***
// self-checking bench for the flash self-programming sequencer
// assumes the flash array model answers every request
`timescale 1ns/1ps
module flash_self_program_sequencer_bench;
    import flash_seq_pkg::*;
    logic        clk_i, rst_i, ctrl_wr_i, key_wr_i, other_wr_i;
    logic        addr_high_wr_i, addr_low_wr_i, flash_done_i;
    logic        cpu_stall_o, flash_req_o, flash_erase_o;
    logic [15:0] ctrl_wdata_i, addr_low_wdata_i, ctrl_rdata_o;
    logic [15:0] addr_low_rdata_o;
    logic [7:0]  key_wdata_i, addr_high_wdata_i, key_rdata_o;
    logic [7:0]  addr_high_rdata_o, delay;
    logic [23:0] prog_word0_i, prog_word1_i, flash_addr_o, flash_addr2_o;
    logic [23:0] flash_data0_o, flash_data1_o;
    int          errors, comparisons;
    // small page keeps the erase base easy to see
    flash_self_program_sequencer #(.PAGE_ADDR_BITS(3)) uut (.*);
    flash_array_model fa (.clk_i, .rst_i, .req_i(flash_req_o),
        .delay_i(delay), .done_o(flash_done_i));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic check(input string n, input logic [23:0] s, e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // k: 0 control, 1 key, 2 high, 3 low, 4 other
    task automatic wr(input int k, input logic [15:0] d);
        @(negedge clk_i);
        {ctrl_wdata_i, addr_low_wdata_i} = {d, d};
        {key_wdata_i, addr_high_wdata_i} = {d[7:0], d[7:0]};
        {other_wr_i, addr_low_wr_i, addr_high_wr_i, key_wr_i,
            ctrl_wr_i} = 5'h01 << k;
        @(negedge clk_i);
        {other_wr_i, addr_low_wr_i, addr_high_wr_i, key_wr_i,
            ctrl_wr_i} = 5'h00;
    endtask : wr
    task automatic go(input logic er, input logic ok, input logic key);
        if (key) begin
            wr(1, 16'h0055);
            wr(1, 16'h00aa);
        end
        wr(0, {1'b1, 14'h0, er});
        check("stall", cpu_stall_o, ok);
        check("start bit", ctrl_rdata_o[15], ok);
        check("request", flash_req_o, ok);
    endtask : go
    task automatic fin;
        for (int i = 0; i < 100 && cpu_stall_o !== 1'b0; i++)
            @(negedge clk_i);
        if (cpu_stall_o !== 1'b0) begin
            errors++;
            conclude();
        end else begin
            check("start cleared", ctrl_rdata_o[15], 1'b0);
        end
    endtask : fin
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {ctrl_wr_i, key_wr_i, other_wr_i, addr_high_wr_i} = 4'h0;
        {addr_low_wr_i, ctrl_wdata_i, addr_low_wdata_i} = 33'h0;
        {key_wdata_i, addr_high_wdata_i} = 16'h0;
        {prog_word0_i, prog_word1_i} = {24'habcdef, 24'h012345};
        {delay, errors, comparisons} = {8'h04, 32'h0, 32'h0};
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        check("control", ctrl_rdata_o, 16'h0000);
        check("key read", key_rdata_o, 8'h00);
        $display("reset test done");
        wr(2, 16'h0012);
        wr(3, 16'h3457);
        check("address", {addr_high_rdata_o, addr_low_rdata_o}, 24'h123457);
        go(1'b1, 1'b1, 1'b1);
        check("erase", flash_erase_o, 1'b1);
        check("page", flash_addr_o, 24'h123450);
        check("page again", flash_addr2_o, 24'h123450);
        check("erase bit", ctrl_rdata_o[0], 1'b1);
        fin();
        go(1'b0, 1'b1, 1'b1);
        check("program", flash_erase_o, 1'b0);
        check("program bit", ctrl_rdata_o[0], 1'b0);
        check("pair", flash_addr_o, 24'h123454);
        check("second", flash_addr2_o, 24'h123456);
        check("word0", flash_data0_o, 24'habcdef);
        check("word1", flash_data1_o, 24'h012345);
        fin();
        $display("erase and program test done");
        go(1'b0, 1'b0, 1'b0);
        wr(1, 16'h0055);
        wr(4, 16'h0000);
        wr(1, 16'h00aa);
        go(1'b0, 1'b0, 1'b0);
        wr(1, 16'h00aa);
        wr(1, 16'h0055);
        go(1'b0, 1'b0, 1'b0);
        wr(1, 16'h0055);
        wr(1, 16'h00aa);
        wr(3, 16'h3450);
        go(1'b0, 1'b0, 1'b0);
        $display("refusal test done");
        delay = 8'h1e;
        go(1'b0, 1'b1, 1'b1);
        wr(3, 16'h0000);
        wr(0, 16'h8000);
        repeat (16) @(negedge clk_i);
        check("slow stall", cpu_stall_o, 1'b1);
        check("low kept", addr_low_rdata_o, 16'h3450);
        fin();
        $display("busy test done");
        conclude();
    end
endmodule : flash_self_program_sequencer_bench
